// ===== logic/lvdc_ctrl.sv
// Voltage detector controller for the combined interrupt and reset mode.
// Assumes comparators high = supply above level; one clock; sync reset.
`timescale 1ns/10ps

module lvdc_ctrl #(
    parameter int DELAY_CYC = lvdc_pkg::DET_DELAY_CYC
) (
    // Clock and power-on reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Option byte mode pair
    input  wire logic       det_mode_sel_hi,
    input  wire logic       det_mode_sel_lo,
    // Supply comparators
    input  wire logic       cmp_high,
    input  wire logic       cmp_low,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // System outputs
    output logic            detector_reset,
    output logic            low_voltage_irq,
    output logic            detector_reset_flag,
    output logic            low_voltage_irq_mask,
    output logic            irq
);
    localparam int CW = $clog2(DELAY_CYC + 1);

    lvdc_sync_if sync_bus ();

    lvdc_sync u_sync (
        .clk      (clk),
        .rst      (rst),
        .cmp_high (cmp_high),
        .cmp_low  (cmp_low),
        .out      (sync_bus)
    );

    logic [1:0]             mode_w;
    logic                   mode_intrst;
    logic                   mode_reset;
    logic [7:0]             lvl_init;
    logic                   init_q;
    logic [7:0]             ctrl_q;
    logic [7:0]             level_q;
    logic [7:0]             status_q;
    logic [7:0]             mask_q;
    logic                   rstf_q;
    logic [CW-1:0]          dly_q;
    logic                   hi_q;
    logic                   lo_q;
    lvdc_pkg::lvdc_state_t  state_q;
    lvdc_pkg::lvdc_state_t  state_d;
    logic                   wen;
    logic                   hi_f;
    logic                   lo_f;
    logic                   ev_lowv;
    logic                   ev_rst;
    logic                   wr_ctrl;
    logic                   wr_level;
    logic                   wr_status;
    logic                   wr_mask;
    logic                   wr_flags;
    logic [7:0]             rd_mux;
    logic [7:0]             ev_vec;
    logic                   dly_end;

    assign dly_end = (dly_q == CW'(DELAY_CYC - 1));

    assign mode_w      = {det_mode_sel_hi, det_mode_sel_lo};
    assign mode_intrst = (mode_w == lvdc_pkg::MODE_INTRST);
    assign mode_reset  = (mode_w == lvdc_pkg::MODE_RESET);
    assign lvl_init    = mode_reset ? lvdc_pkg::LVL_RST_RESET
                       : mode_intrst ? lvdc_pkg::LVL_RST_INTRST
                       : lvdc_pkg::LVL_RST_INT;
    assign wen         = ctrl_q[lvdc_pkg::CTRL_WEN_BIT];

    assign wr_ctrl   = wr && (addr == lvdc_pkg::ADDR_CTRL);
    assign wr_level  = wr && (addr == lvdc_pkg::ADDR_LEVEL) && wen;
    assign wr_status = wr && (addr == lvdc_pkg::ADDR_STATUS);
    assign wr_mask   = wr && (addr == lvdc_pkg::ADDR_MASK);
    assign wr_flags  = wr && (addr == lvdc_pkg::ADDR_FLAGS);

    // Filtered comparator levels: a change must persist for the delay
    assign hi_f = hi_q;
    assign lo_f = lo_q;

    always_ff @(posedge clk)
    begin
        if (rst)
            dly_q <= '0;
        else if (sync_bus.above_high != hi_q || sync_bus.above_low != lo_q)
            dly_q <= (dly_q == CW'(DELAY_CYC - 1)) ? '0 : dly_q + 1'b1;
        else
            dly_q <= '0;
    end

    // Levels adopted only when the delay count ends; glitches shorter are dropped
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hi_q <= 1'b0;
            lo_q <= 1'b0;
        end
        else if (dly_q == CW'(DELAY_CYC - 1))
        begin
            hi_q <= sync_bus.above_high;
            lo_q <= sync_bus.above_low;
        end
    end

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            lvdc_pkg::LVDC_HELD:
                if (hi_f)
                    state_d = lvdc_pkg::LVDC_RUN;
            lvdc_pkg::LVDC_RUN:
                if (!hi_f && !wen)
                    state_d = lvdc_pkg::LVDC_WARNED;
            lvdc_pkg::LVDC_WARNED:
                if (!lo_f && !wen)
                    state_d = lvdc_pkg::LVDC_DET_RST;
            lvdc_pkg::LVDC_DET_RST:
                if (hi_f)
                    state_d = lvdc_pkg::LVDC_RUN;
        endcase
    end

    // Warned state stays put above high: no second interrupt
    assign ev_lowv = mode_intrst && (state_q == lvdc_pkg::LVDC_RUN)
                  && (state_d == lvdc_pkg::LVDC_WARNED);
    assign ev_rst  = mode_intrst && (state_q == lvdc_pkg::LVDC_DET_RST)
                  && (state_d == lvdc_pkg::LVDC_RUN);
    assign ev_vec  = {6'h0, ev_rst, ev_lowv};

    always_ff @(posedge clk)
    begin
        if (rst)
            state_q <= lvdc_pkg::LVDC_HELD;
        else
            state_q <= state_d;
    end

    property p_held_reset;
        @(posedge clk) disable iff (rst)
            mode_intrst && (state_q == lvdc_pkg::LVDC_HELD)
            |-> detector_reset;
    endproperty
    a_held_reset: assert property (p_held_reset)
        else $error("detector reset not held before supply rise");

    property p_release;
        @(posedge clk) disable iff (rst)
            (state_q == lvdc_pkg::LVDC_HELD) && hi_f
            |=> (state_q == lvdc_pkg::LVDC_RUN);
    endproperty
    a_release: assert property (p_release)
        else $error("detector reset not released above high level");

    property p_irq_on_fall;
        @(posedge clk) disable iff (rst)
            mode_intrst && (state_q == lvdc_pkg::LVDC_RUN) && !hi_f && !wen
            |=> status_q[lvdc_pkg::EV_LOWV_BIT];
    endproperty
    a_irq_on_fall: assert property (p_irq_on_fall)
        else $error("no low voltage event below high level");

    property p_det_rst;
        @(posedge clk) disable iff (rst)
            (state_q == lvdc_pkg::LVDC_WARNED) && !lo_f && !wen
            |=> (state_q == lvdc_pkg::LVDC_DET_RST);
    endproperty
    a_det_rst: assert property (p_det_rst)
        else $error("no detector reset below low level");

    property p_no_reirq;
        @(posedge clk) disable iff (rst)
            (state_q == lvdc_pkg::LVDC_WARNED) |-> !ev_lowv;
    endproperty
    a_no_reirq: assert property (p_no_reirq)
        else $error("second low voltage event without low drop");

    property p_wen_irq;
        @(posedge clk) disable iff (rst)
            wen |-> !ev_lowv;
    endproperty
    a_wen_irq: assert property (p_wen_irq)
        else $error("low voltage event while write enable set");

    // Mode-dependent init is taken one cycle after release, not under reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            init_q  <= 1'b1;
            ctrl_q  <= 8'h00;
            level_q <= 8'h00;
        end
        else
        begin
            init_q <= 1'b0;
            if (wr_ctrl)
                ctrl_q <= wdata;
            if (init_q)
                level_q <= lvl_init;
            else if (wr_level)
                level_q <= wdata;
        end
    end

    // Sticky events: set wins over write-one clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            status_q <= 8'h00;
            mask_q   <= lvdc_pkg::MASK_RST;
        end
        else
        begin
            status_q <= (status_q & ~(wr_status ? wdata : 8'h00)) | ev_vec;
            if (wr_mask)
                mask_q <= wdata;
        end
    end

    // Detector reset flag: set on release, cleared by writing one
    always_ff @(posedge clk)
    begin
        if (rst)
            rstf_q <= 1'b0;
        else if (ev_rst)
            rstf_q <= 1'b1;
        else if (wr_flags && wdata[lvdc_pkg::FLG_RSTF_BIT])
            rstf_q <= 1'b0;
    end

    assign rd_mux = (addr == lvdc_pkg::ADDR_CTRL)   ? ctrl_q
                  : (addr == lvdc_pkg::ADDR_LEVEL)  ? level_q
                  : (addr == lvdc_pkg::ADDR_STATUS) ? status_q
                  : (addr == lvdc_pkg::ADDR_MASK)   ? mask_q
                  : (addr == lvdc_pkg::ADDR_FLAGS)
                    ? {4'h0, lo_q, hi_q, detector_reset, rstf_q}
                  : 8'h00;

    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= 8'h00;
        else
            rdata <= rd ? rd_mux : 8'h00;
    end

    // Reset masked while write enable is set, except the power-up hold
    assign detector_reset = mode_intrst
        && ((state_q == lvdc_pkg::LVDC_HELD)
         || (state_q == lvdc_pkg::LVDC_DET_RST && !wen));
    assign low_voltage_irq      = status_q[lvdc_pkg::EV_LOWV_BIT];
    assign low_voltage_irq_mask = mask_q[lvdc_pkg::EV_LOWV_BIT];
    assign detector_reset_flag  = rstf_q;
    assign irq = |(status_q & ~mask_q);

    property p_wen_reset;
        @(posedge clk) disable iff (rst)
            wen && (state_q != lvdc_pkg::LVDC_HELD) |-> !detector_reset;
    endproperty
    a_wen_reset: assert property (p_wen_reset)
        else $error("detector reset while write enable set");

    property p_mask_set;
        @(posedge clk) disable iff (rst)
            $fell(rst) |-> mask_q[lvdc_pkg::EV_LOWV_BIT];
    endproperty
    a_mask_set: assert property (p_mask_set)
        else $error("interrupt mask flag clear after reset");

    property p_init_wen;
        @(posedge clk) disable iff (rst)
            init_q |-> !wen;
    endproperty
    a_init_wen: assert property (p_init_wen)
        else $error("write enable set at start");

    property p_level_lock;
        @(posedge clk) disable iff (rst)
            wr && (addr == lvdc_pkg::ADDR_LEVEL) && !wen && !init_q
            |=> $stable(level_q);
    endproperty
    a_level_lock: assert property (p_level_lock)
        else $error("locked level register changed");

    property p_init_level;
        @(posedge clk) disable iff (rst)
            init_q && mode_intrst |=> (level_q == lvdc_pkg::LVL_RST_INTRST);
    endproperty
    a_init_level: assert property (p_init_level)
        else $error("level register not initialised to zero");

    property p_filter;
        @(posedge clk) disable iff (rst)
            $changed(hi_q) |-> $past(dly_end);
    endproperty
    a_filter: assert property (p_filter)
        else $error("high level adopted before delay count ended");

    property p_rstf_set;
        @(posedge clk) disable iff (rst)
            ev_rst |=> rstf_q;
    endproperty
    a_rstf_set: assert property (p_rstf_set)
        else $error("detector reset flag not set on release");
endmodule

// ===== shared/lvdc_pkg.sv
// Constants shared by the voltage detector reset/interrupt controller.
// Assumes a single 40 MHz system clock and synchronous active-high reset.
package lvdc_pkg;
    // Register port map (word indices on an 8-bit address)
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LEVEL  = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_MASK   = 8'h03;
    localparam logic [7:0] ADDR_FLAGS  = 8'h04;

    // Bit positions
    localparam int CTRL_WEN_BIT   = 7;
    localparam int LVL_MODE_BIT   = 7;
    localparam int LVL_LEVEL_BIT  = 0;
    localparam int EV_LOWV_BIT    = 0;
    localparam int EV_RESET_BIT   = 1;
    localparam int FLG_RSTF_BIT   = 0;
    localparam int FLG_DETRST_BIT = 1;
    localparam int FLG_HIGH_BIT   = 2;
    localparam int FLG_LOW_BIT    = 3;

    // Reset values of the level register per mode, and of the mask register
    localparam logic [7:0] LVL_RST_INTRST = 8'h00;
    localparam logic [7:0] LVL_RST_RESET  = 8'h81;
    localparam logic [7:0] LVL_RST_INT    = 8'h01;
    localparam logic [7:0] MASK_RST       = 8'h03;

    // Mode select pair {hi, lo}
    localparam logic [1:0] MODE_INTRST = 2'h2;
    localparam logic [1:0] MODE_RESET  = 2'h3;
    localparam logic [1:0] MODE_INT    = 2'h1;

    // Timing
    localparam int CLK_MHZ         = 40;
    localparam int DET_DELAY_US    = 300;
    localparam int DET_DELAY_CYC   = DET_DELAY_US * CLK_MHZ;
    localparam int STAB_US         = 400;
    localparam int STAB_CYC        = STAB_US * CLK_MHZ;

    typedef enum logic [1:0] {
        LVDC_HELD,
        LVDC_RUN,
        LVDC_WARNED,
        LVDC_DET_RST
    } lvdc_state_t;
endpackage

// ===== shared/lvdc_sync_if.sv
// Carrier between comparator synchroniser and the controller.
// Assumes both ends run on the one system clock.
`timescale 1ns/10ps
interface lvdc_sync_if;
    logic above_high;
    logic above_low;
    modport src (output above_high, output above_low);
    modport dst (input  above_high, input  above_low);
endinterface

// ===== logic/lvdc_sync.sv
// Two-stage synchroniser for both supply comparator outputs.
// Assumes comparators are asynchronous analog levels.
`timescale 1ns/10ps
module lvdc_sync (
    // Clock and reset
    input  wire logic   clk,
    input  wire logic   rst,
    // Raw comparators
    input  wire logic   cmp_high,
    input  wire logic   cmp_low,
    // Synchronised levels
    lvdc_sync_if.src    out
);
    logic [1:0] stage1_q;
    logic [1:0] stage2_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            stage1_q <= 2'h0;
            stage2_q <= 2'h0;
        end
        else
        begin
            stage1_q <= {cmp_high, cmp_low};
            stage2_q <= stage1_q;
        end
    end

    assign out.above_high = stage2_q[1];
    assign out.above_low  = stage2_q[0];
endmodule

// ===== tb/lvdc_supply_model.sv
// Behavioural supply comparators facing the detector controller.
// Assumes the bench picks a supply band: 0 below low, 1 between, 2 above.
`timescale 1ns/10ps
module lvdc_supply_model (
    // Supply band from the bench
    input  wire logic [1:0] band,
    // Comparator outputs, asynchronous to the system clock
    output logic            cmp_high,
    output logic            cmp_low
);
    // Analog settling, off the clock edge on purpose
    always @(band)
    begin
        #3;
        cmp_high = (band == 2'h2);
        cmp_low  = (band != 2'h0);
    end
    initial
    begin
        cmp_high = 1'b0;
        cmp_low  = 1'b0;
    end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the detector controller, register port driven.
// Assumes the supply model and a 40 MHz clock with synchronous reset.
`timescale 1ns/10ps
module testbench;
    localparam int DLY = 8;
    localparam int WT  = DLY + 12;
    // 10 us high on the reset pin at 40 MHz
    localparam int EXT_RST_CYC = 400;
    logic       clk;
    logic       rst;
    logic       det_mode_sel_hi;
    logic       det_mode_sel_lo;
    logic [1:0] band;
    logic       cmp_high;
    logic       cmp_low;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic       detector_reset;
    logic       low_voltage_irq;
    logic       detector_reset_flag;
    logic       low_voltage_irq_mask;
    logic       irq;
    logic [7:0] v;
    int         fails;
    int         comparisons;
    int         cyc;

    lvdc_supply_model sup_u (.band(band), .cmp_high(cmp_high),
        .cmp_low(cmp_low));
    // Short detection delay keeps the run brief
    lvdc_ctrl #(.DELAY_CYC(DLY)) dut_u (.clk(clk), .rst(rst),
        .det_mode_sel_hi(det_mode_sel_hi), .det_mode_sel_lo(det_mode_sel_lo),
        .cmp_high(cmp_high), .cmp_low(cmp_low), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .detector_reset(detector_reset),
        .low_voltage_irq(low_voltage_irq),
        .detector_reset_flag(detector_reset_flag),
        .low_voltage_irq_mask(low_voltage_irq_mask), .irq(irq));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Bounded wait: 0 reset on, 1 reset off, 2 interrupt raised
    task automatic wait_for(input int sel, input int n);
        int   i;
        logic hit;
        hit = 1'b0;
        for (i = 0; i < n && !hit; i++)
        begin
            @(posedge clk);
            #1;
            hit = sel == 0 ? detector_reset === 1'b1 :
                  sel == 1 ? detector_reset === 1'b0 :
                  low_voltage_irq === 1'b1;
        end
        check({7'h00, hit}, 8'h01);
    endtask

    task automatic pulse_reset(input logic [1:0] mode, input int n);
        @(posedge clk);
        {det_mode_sel_hi, det_mode_sel_lo} <= mode;
        rst <= 1'b1;
        repeat (n) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    task automatic test_done();
        $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            test_done();
        end
    end

    initial
    begin
        fails = 0;
        comparisons = 0;
        cyc = 0;
        rst = 1'b1;
        {det_mode_sel_hi, det_mode_sel_lo} = lvdc_pkg::MODE_INTRST;
        band = 2'h0;
        addr = 8'h00;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        pulse_reset(lvdc_pkg::MODE_INTRST, 20);
        rd_reg(lvdc_pkg::ADDR_LEVEL, v);
        check(v, lvdc_pkg::LVL_RST_INTRST);
        rd_reg(lvdc_pkg::ADDR_CTRL, v);
        check(v & 8'h80, 8'h00);
        rd_reg(lvdc_pkg::ADDR_MASK, v);
        check(v, lvdc_pkg::MASK_RST);
        check({7'h00, low_voltage_irq_mask}, 8'h01);
        check({7'h00, detector_reset}, 8'h01);
        // Locked level register ignores writes
        wr_reg(lvdc_pkg::ADDR_LEVEL, 8'h81);
        rd_reg(lvdc_pkg::ADDR_LEVEL, v);
        check(v, 8'h00);
        $display("test init done");
        band = 2'h2;
        wait_for(1, WT);
        repeat (WT) @(posedge clk);
        check({7'h00, detector_reset_flag}, 8'h00);
        wr_reg(lvdc_pkg::ADDR_CTRL, 8'h80);
        repeat (5) @(posedge clk);
        wr_reg(lvdc_pkg::ADDR_LEVEL, 8'h00);
        wr_reg(lvdc_pkg::ADDR_CTRL, 8'h00);
        wr_reg(lvdc_pkg::ADDR_STATUS, 8'h03);
        wr_reg(lvdc_pkg::ADDR_MASK, 8'h00);
        $display("test power up done");
        band = 2'h1;
        wait_for(2, WT);
        rd_reg(lvdc_pkg::ADDR_STATUS, v);
        check(v & 8'h01, 8'h01);
        check({7'h00, irq}, 8'h01);
        check({7'h00, detector_reset}, 8'h00);
        wr_reg(lvdc_pkg::ADDR_STATUS, 8'h01);
        #1;
        check({7'h00, irq}, 8'h00);
        band = 2'h2;
        repeat (WT) @(posedge clk);
        rd_reg(lvdc_pkg::ADDR_STATUS, v);
        check(v & 8'h01, 8'h00);
        $display("test warning done");
        band = 2'h0;
        wait_for(0, WT);
        band = 2'h2;
        wait_for(1, WT);
        check({7'h00, detector_reset_flag}, 8'h01);
        rd_reg(lvdc_pkg::ADDR_FLAGS, v);
        check(v & 8'h01, 8'h01);
        wr_reg(lvdc_pkg::ADDR_FLAGS, 8'h01);
        #1;
        check({7'h00, detector_reset_flag}, 8'h00);
        wr_reg(lvdc_pkg::ADDR_STATUS, 8'h03);
        // Write enable held: a full drop must stay silent
        wr_reg(lvdc_pkg::ADDR_CTRL, 8'h80);
        band = 2'h1;
        repeat (WT) @(posedge clk);
        band = 2'h0;
        repeat (WT) @(posedge clk);
        check({7'h00, low_voltage_irq}, 8'h00);
        check({7'h00, detector_reset}, 8'h00);
        $display("test masked done");
        pulse_reset(lvdc_pkg::MODE_RESET, 20);
        rd_reg(lvdc_pkg::ADDR_LEVEL, v);
        check(v, lvdc_pkg::LVL_RST_RESET);
        pulse_reset(lvdc_pkg::MODE_INT, EXT_RST_CYC);
        rd_reg(lvdc_pkg::ADDR_LEVEL, v);
        check(v, lvdc_pkg::LVL_RST_INT);
        check({7'h00, low_voltage_irq_mask}, 8'h01);
        $display("test modes done");
        test_done();
    end
endmodule
